// File: hw/flash_host_regs.vh
// constants for the parallel flash host controller
// Functional notes
// R1: device floats data while output strobe high
// R2: width select high gives sixteen data lines
// R3: byte mode: eight lines, line fifteen is address
// R4: protect pin low blocks outermost sector writes
// R5: high voltage on protect pin skips unlocks
// R6: buffer load: unlocks, load command, count minus one
// R7: buffer data must stay in first page
// R8: confirm command starts buffer programming
// R9: oversize count, wrong sector, missing confirm abort
// R10: abort status: abort flag, inverted poll, toggle
// R11: abort needs abort reset sequence afterwards
// R12: reprogramming never turns zero into one
// R13: high voltage read reports sector protection
// R14: high voltage read returns maker code
// R15: high voltage read returns security lock code
// R16: only complete sequences start program or erase
// R17: strobes shorter than five nanoseconds ignored
// R18: write needs select and write low, output high
// R19: first command after power-up held strobes dropped
// R20: erase suspend settles within twenty microseconds
// R21: failure or autoselect needs reset to read mode
// R22: single program: unlocks, program command, data
// R23: address latched on write fall, data on rise
// R24: busy held low through interrupting hardware reset
// R25: busy low while embedded operation runs
`ifndef FLASH_HOST_REGS_VH
`define FLASH_HOST_REGS_VH

// ****
// user operation codes
// ****
`define OP_READ         4'h0
`define OP_WRITE        4'h1
`define OP_PROGRAM      4'h2
`define OP_BUF_START    4'h3
`define OP_BUF_DATA     4'h4
`define OP_BUF_CONFIRM  4'h5
`define OP_ABORT_RESET  4'h6
`define OP_SW_RESET     4'h7
`define OP_HW_RESET     4'h8
`define OP_SUSPEND      4'h9
`define OP_RESUME       4'hA
`define OP_AUTOSEL_READ 4'hB

// ****
// flash command cycles
// ****
`define UNLOCK1_ADDR    24'h000555
`define UNLOCK2_ADDR    24'h0002AA
`define UNLOCK1_DATA    16'h00AA
`define UNLOCK2_DATA    16'h0055
`define CMD_PROGRAM     16'h00A0
`define CMD_BUF_LOAD    16'h0025
`define CMD_BUF_CONFIRM 16'h0029
`define CMD_RESET       16'h00F0
`define CMD_SUSPEND     16'h00B0
`define CMD_RESUME      16'h0030

// ****
// field positions and sizes
// ****
`define SECTOR_LSB       16
`define PAGE_LSB         5
`define BUF_WORDS        16'h0020
`define BUF_BYTES        16'h0040
`define BIT_POLLING      7
`define BIT_TIME_LIMIT   5
`define BIT_BUFFER_ABORT 1

// ****
// timing
// ****
`define CLK_NS          5
`define T_GLITCH_NS     5
`define T_WP_NS         35
`define T_WPH_NS        20
`define T_ACC_NS        100
`define T_RP_NS         500
`define T_BUSY_NS       90
`define T_SUSPEND_US    20
`define T_OP_MAX_US     500
`define WP_CYC          ((`T_WP_NS + `CLK_NS - 1) / `CLK_NS)
`define GLITCH_CYC      ((`T_GLITCH_NS + `CLK_NS - 1) / `CLK_NS)
`define WPH_CYC         ((`T_WPH_NS + `CLK_NS - 1) / `CLK_NS)
`define ACC_CYC         ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define RP_CYC          ((`T_RP_NS + `CLK_NS - 1) / `CLK_NS)
`define BUSY_CYC        ((`T_BUSY_NS + `CLK_NS - 1) / `CLK_NS)
`define SUSPEND_CYC     ((`T_SUSPEND_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define OP_MAX_CYC      ((`T_OP_MAX_US * 1000) / `CLK_NS)

`endif

// File: hw/flash_bus_cycle.v
// one read or write cycle on the flash pins
`timescale 1ns/10ps
`include "flash_host_regs.vh"

module flash_bus_cycle #(
  parameter ADDR_W = 24
) (
  // clock and reset
  input  wire              clk,
  input  wire              rst,
  // request
  input  wire              start,
  input  wire              is_read,
  input  wire              byte_mode,
  input  wire [ADDR_W-1:0] addr_in,
  input  wire              lsb_in,
  input  wire [15:0]       wdata,
  output reg               done,
  output reg  [15:0]       rdata,
  // flash pins
  output reg               ce_n,
  output reg               oe_n,
  output reg               we_n,
  output reg  [ADDR_W-1:0] addr_out,
  output reg  [15:0]       dq_out,
  output reg  [15:0]       dq_oe_n,
  input  wire [15:0]       dq_in
);

  localparam [2:0] C_IDLE  = 3'h0;
  localparam [2:0] C_SETUP = 3'h1;
  localparam [2:0] C_PULSE = 3'h2;
  localparam [2:0] C_HOLD  = 3'h3;
  localparam [2:0] C_READ  = 3'h4;
  localparam [2:0] C_GAP   = 3'h5;

  // pulse is never at or below the glitch width
  localparam integer PULSE_N = (`WP_CYC > `GLITCH_CYC) ? `WP_CYC : (`GLITCH_CYC + 1);
  localparam integer HIGH_N  = `WPH_CYC;
  localparam integer READ_N  = `ACC_CYC;
  localparam [7:0] PULSE_CYC = PULSE_N[7:0];
  localparam [7:0] HIGH_CYC  = HIGH_N[7:0];
  localparam [7:0] READ_CYC  = READ_N[7:0];

  reg [2:0] state_reg;
  reg [7:0] cnt_reg;
  reg       read_reg;
  reg       bmode_reg;

  always @(posedge clk) begin
    if (rst) begin
      state_reg <= C_IDLE;
      cnt_reg   <= 8'h00;
      read_reg  <= 1'b0;
      bmode_reg <= 1'b0;
      done      <= 1'b0;
      rdata     <= 16'h0000;
      ce_n      <= 1'b1;
      oe_n      <= 1'b1;
      we_n      <= 1'b1; // see R19
      addr_out  <= {ADDR_W{1'b0}};
      dq_out    <= 16'h0000;
      dq_oe_n   <= 16'hFFFF;
    end else begin
      done <= 1'b0;
      case (state_reg)
        C_IDLE: begin
          if (start) begin
            read_reg  <= is_read;
            bmode_reg <= byte_mode;
            addr_out  <= addr_in;
            ce_n      <= 1'b0;
            oe_n      <= 1'b1;
            cnt_reg   <= 8'h00;
            // byte mode: line fifteen carries the lowest address bit
            if (byte_mode) begin // see R3
              dq_out  <= {lsb_in, 7'h00, wdata[7:0]};
              dq_oe_n <= is_read ? 16'h7FFF : 16'h7F00;
            end else begin // see R2
              dq_out  <= wdata;
              dq_oe_n <= is_read ? 16'hFFFF : 16'h0000;
            end
            state_reg <= is_read ? C_READ : C_SETUP;
            if (is_read) begin
              oe_n <= 1'b0; // see R1
            end
          end
        end
        C_SETUP: begin
          // address is stable before the falling write edge
          we_n      <= 1'b0; // see R23
          state_reg <= C_PULSE;
        end
        C_PULSE: begin
          // select and write low with output high, long past the glitch width
          if (cnt_reg == PULSE_CYC - 8'h01) begin // see R17, R18
            we_n      <= 1'b1;
            cnt_reg   <= 8'h00;
            state_reg <= C_HOLD;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        C_HOLD: begin
          // data held past the rising write edge
          ce_n      <= 1'b1; // see R23
          state_reg <= C_GAP;
        end
        C_READ: begin
          if (cnt_reg == READ_CYC - 8'h01) begin
            rdata     <= bmode_reg ? {8'h00, dq_in[7:0]} : dq_in;
            ce_n      <= 1'b1;
            oe_n      <= 1'b1;
            cnt_reg   <= 8'h00;
            state_reg <= C_GAP;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        C_GAP: begin
          dq_oe_n <= 16'hFFFF;
          if (cnt_reg == HIGH_CYC - 8'h01) begin
            done      <= 1'b1;
            cnt_reg   <= 8'h00;
            state_reg <= C_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        default: begin
          state_reg <= C_IDLE;
        end
      endcase
    end
  end

endmodule // flash_bus_cycle

// File: hw/flash_host_ctrl.v
// host-side command sequencer for a parallel nor flash
`timescale 1ns/10ps
`include "flash_host_regs.vh"

module flash_host_ctrl #(
  parameter ADDR_W     = 24,
  parameter OP_MAX_CYC = `OP_MAX_CYC
) (
  // clock and reset
  input  wire              clk,
  input  wire              rst,
  // user command port
  input  wire              cmd_valid,
  input  wire [3:0]        cmd_op,
  input  wire [ADDR_W-1:0] cmd_addr,
  input  wire              cmd_lsb,
  input  wire [15:0]       cmd_data,
  output reg               cmd_ready,
  output reg               rsp_valid,
  output reg  [15:0]       rsp_data,
  output reg               rsp_error,
  output reg               need_reset,
  output reg               abort_pending,
  // user configuration levels
  input  wire              cfg_byte_mode,
  input  wire              cfg_protect,
  input  wire              cfg_accel,
  // flash pins
  output wire              ce_n,
  output wire              oe_n,
  output wire              we_n,
  output wire [ADDR_W-1:0] addr_out,
  output wire [15:0]       dq_out,
  output wire [15:0]       dq_oe_n,
  input  wire [15:0]       dq_in,
  output reg               reset_n,
  output reg               byte_n,
  output reg               protect_accel_low,
  output reg               protect_accel_hv,
  output reg               autoselect_hv,
  input  wire              ready_busy_n
);

  localparam [3:0] S_IDLE    = 4'h0;
  localparam [3:0] S_STEP    = 4'h1;
  localparam [3:0] S_WAIT    = 4'h2;
  localparam [3:0] S_BUSYDLY = 4'h3;
  localparam [3:0] S_BUSY    = 4'h4;
  localparam [3:0] S_STAT    = 4'h5;
  localparam [3:0] S_STATW   = 4'h6;
  localparam [3:0] S_HWRST   = 4'h7;
  localparam [3:0] S_HWWAIT  = 4'h8;
  localparam [3:0] S_SUSP    = 4'h9;
  localparam [3:0] S_DONE    = 4'hA;

  localparam [31:0] RP_CYC   = `RP_CYC;
  localparam [31:0] BUSY_CYC = `BUSY_CYC;
  localparam [31:0] SUSP_CYC = `SUSPEND_CYC;
  localparam [31:0] MAX_CYC  = OP_MAX_CYC;
  localparam [15:0] MAX_WORD = `BUF_WORDS - 16'h0001;
  localparam [15:0] MAX_BYTE = `BUF_BYTES - 16'h0001;

  // ****
  // state
  // ****
  reg [3:0]        state_reg;
  reg [3:0]        op_reg;
  reg [1:0]        step_reg;
  reg [ADDR_W-1:0] addr_reg;
  reg              lsb_reg;
  reg [15:0]       data_reg;
  reg [31:0]       cnt_reg;
  reg              err_reg;
  reg              buf_open_reg;
  reg [15:0]       buf_left_reg;
  reg [ADDR_W-1:0] buf_addr_reg;
  reg              buf_first_reg;
  reg [15:0]       last_data_reg;
  reg              cyc_start_reg;

  wire        cyc_done;
  wire [15:0] cyc_rdata;

  // ****
  // sequence table
  // ****
  reg [ADDR_W-1:0] seq_addr;
  reg [15:0]       seq_data;
  reg              seq_read;
  reg              seq_last;

  always @* begin
    seq_addr = addr_reg;
    seq_data = data_reg;
    seq_read = 1'b0;
    seq_last = (step_reg == 2'h3);
    case (step_reg)
      2'h0: begin
        seq_addr = `UNLOCK1_ADDR;
        seq_data = `UNLOCK1_DATA;
      end
      2'h1: begin
        seq_addr = `UNLOCK2_ADDR;
        seq_data = `UNLOCK2_DATA;
      end
      2'h2: begin
        if (op_reg == `OP_BUF_START) begin
          seq_data = `CMD_BUF_LOAD; // see R6
        end else if (op_reg == `OP_ABORT_RESET) begin
          seq_addr = `UNLOCK1_ADDR;
          seq_data = `CMD_RESET; // see R11
          seq_last = 1'b1;
        end else begin
          seq_addr = `UNLOCK1_ADDR;
          seq_data = `CMD_PROGRAM; // see R22
        end
      end
      default: begin
        if (op_reg == `OP_BUF_CONFIRM) begin
          seq_data = `CMD_BUF_CONFIRM; // see R8
        end else if (op_reg == `OP_SW_RESET) begin
          seq_data = `CMD_RESET;
        end else if (op_reg == `OP_SUSPEND) begin
          seq_data = `CMD_SUSPEND;
        end else if (op_reg == `OP_RESUME) begin
          seq_data = `CMD_RESUME;
        end else if (op_reg == `OP_READ || op_reg == `OP_AUTOSEL_READ) begin
          seq_read = 1'b1;
        end
      end
    endcase
  end

  // ****
  // acceptance checks
  // ****
  reg       refuse;
  reg [1:0] first_step;
  wire      same_sector = cmd_addr[ADDR_W-1:`SECTOR_LSB] == buf_addr_reg[ADDR_W-1:`SECTOR_LSB];
  wire      same_page   = cmd_addr[ADDR_W-1:`PAGE_LSB] == buf_addr_reg[ADDR_W-1:`PAGE_LSB];

  always @* begin
    refuse     = 1'b0;
    first_step = 2'h3;
    if (cmd_op == `OP_PROGRAM) begin
      first_step = cfg_accel ? 2'h2 : 2'h0; // see R5
    end else if (cmd_op == `OP_BUF_START || cmd_op == `OP_ABORT_RESET) begin
      first_step = 2'h0;
    end
    // a failed or aborted device is only ever sent its reset
    if (need_reset && cmd_op != `OP_SW_RESET && cmd_op != `OP_HW_RESET) begin // see R21
      refuse = 1'b1;
    end else if (abort_pending && cmd_op != `OP_ABORT_RESET && cmd_op != `OP_HW_RESET) begin
      refuse = 1'b1; // see R11
    end else if (cmd_op == `OP_BUF_START) begin
      refuse = cmd_data > (cfg_byte_mode ? MAX_BYTE : MAX_WORD); // see R9
    end else if (cmd_op == `OP_BUF_DATA) begin
      refuse = !buf_open_reg || buf_left_reg == 16'h0000 || !same_sector ||
               (!buf_first_reg && !same_page); // see R7, R9
    end else if (cmd_op == `OP_BUF_CONFIRM) begin
      refuse = !buf_open_reg || buf_left_reg != 16'h0000 || !same_sector; // see R9
    end else if (cmd_op > `OP_AUTOSEL_READ) begin
      refuse = 1'b1; // see R16
    end
  end

  // ****
  // sequencer
  // ****
  always @(posedge clk) begin
    if (rst) begin
      state_reg         <= S_IDLE;
      op_reg            <= `OP_READ;
      step_reg          <= 2'h0;
      addr_reg          <= {ADDR_W{1'b0}};
      lsb_reg           <= 1'b0;
      data_reg          <= 16'h0000;
      cnt_reg           <= 32'h00000000;
      err_reg           <= 1'b0;
      buf_open_reg      <= 1'b0;
      buf_left_reg      <= 16'h0000;
      buf_addr_reg      <= {ADDR_W{1'b0}};
      buf_first_reg     <= 1'b0;
      last_data_reg     <= 16'h0000;
      cyc_start_reg     <= 1'b0;
      cmd_ready         <= 1'b0;
      rsp_valid         <= 1'b0;
      rsp_data          <= 16'h0000;
      rsp_error         <= 1'b0;
      need_reset        <= 1'b0;
      abort_pending     <= 1'b0;
      reset_n           <= 1'b1;
      byte_n            <= 1'b1;
      protect_accel_low <= 1'b0;
      protect_accel_hv  <= 1'b0;
      autoselect_hv     <= 1'b0;
    end else begin
      cyc_start_reg     <= 1'b0;
      rsp_valid         <= 1'b0;
      byte_n            <= !cfg_byte_mode; // see R2, R3
      protect_accel_low <= cfg_protect && !cfg_accel; // see R4
      protect_accel_hv  <= cfg_accel; // see R5
      case (state_reg)
        S_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            op_reg    <= cmd_op;
            addr_reg  <= cmd_addr;
            lsb_reg   <= cmd_lsb;
            data_reg  <= cmd_data;
            step_reg  <= first_step;
            err_reg   <= 1'b0;
            cnt_reg   <= 32'h00000000;
            if (refuse) begin
              err_reg   <= 1'b1;
              state_reg <= S_DONE;
            end else if (cmd_op == `OP_HW_RESET) begin
              reset_n   <= 1'b0;
              state_reg <= S_HWRST;
            end else begin
              autoselect_hv <= (cmd_op == `OP_AUTOSEL_READ); // see R13, R14, R15
              state_reg     <= S_STEP;
            end
            if (!refuse && cmd_op == `OP_BUF_START) begin
              buf_open_reg  <= 1'b1;
              buf_addr_reg  <= cmd_addr;
              buf_left_reg  <= cmd_data + 16'h0001;
              buf_first_reg <= 1'b1;
            end
            if (!refuse && cmd_op == `OP_BUF_DATA) begin
              buf_left_reg  <= buf_left_reg - 16'h0001;
              buf_first_reg <= 1'b0;
              if (buf_first_reg) begin
                buf_addr_reg <= cmd_addr; // see R7
              end
            end
            if (!refuse && (cmd_op == `OP_BUF_DATA || cmd_op == `OP_PROGRAM)) begin
              last_data_reg <= cmd_data;
            end
            if (!refuse && cmd_op == `OP_BUF_CONFIRM) begin
              buf_open_reg <= 1'b0;
            end
            if (!refuse && cmd_op == `OP_SW_RESET) begin
              need_reset <= 1'b0; // see R21
            end
            if (!refuse && cmd_op == `OP_ABORT_RESET) begin
              abort_pending <= 1'b0;
              buf_open_reg  <= 1'b0;
            end
          end
        end
        S_STEP: begin
          cyc_start_reg <= 1'b1;
          state_reg     <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            if (!seq_last) begin
              step_reg  <= step_reg + 2'h1;
              state_reg <= S_STEP;
            end else if (op_reg == `OP_PROGRAM || op_reg == `OP_BUF_CONFIRM) begin
              state_reg <= S_BUSYDLY;
            end else if (op_reg == `OP_SUSPEND) begin
              state_reg <= S_SUSP;
            end else begin
              autoselect_hv <= 1'b0;
              rsp_data      <= cyc_rdata;
              state_reg     <= S_DONE;
            end
          end
        end
        S_BUSYDLY: begin
          if (cnt_reg == BUSY_CYC) begin
            cnt_reg   <= 32'h0;
            state_reg <= S_BUSY;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        S_BUSY: begin
          // busy pin released means back in read mode
          if (ready_busy_n) begin // see R25
            state_reg <= S_DONE;
          end else if (cnt_reg == MAX_CYC) begin
            state_reg <= S_STAT;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        S_STAT: begin
          op_reg        <= `OP_READ;
          step_reg      <= 2'h3;
          cyc_start_reg <= 1'b1;
          state_reg     <= S_STATW;
        end
        S_STATW: begin
          if (cyc_done) begin
            rsp_data <= cyc_rdata;
            err_reg  <= 1'b1;
            if (cyc_rdata[`BIT_BUFFER_ABORT] &&
                cyc_rdata[`BIT_POLLING] != last_data_reg[`BIT_POLLING]) begin // see R10
              abort_pending <= 1'b1;
            end else begin
              need_reset <= 1'b1; // see R21
            end
            state_reg <= S_DONE;
          end
        end
        S_SUSP: begin
          if (cnt_reg == SUSP_CYC) begin // see R20
            state_reg <= S_DONE;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        S_HWRST: begin
          if (cnt_reg == RP_CYC) begin
            reset_n   <= 1'b1;
            cnt_reg   <= 32'h0;
            state_reg <= S_HWWAIT;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        S_HWWAIT: begin
          // an interrupted operation keeps busy low until read mode
          if (cnt_reg > BUSY_CYC && ready_busy_n) begin // see R24
            need_reset    <= 1'b0;
            abort_pending <= 1'b0;
            buf_open_reg  <= 1'b0;
            state_reg     <= S_DONE;
          end else if (cnt_reg == MAX_CYC) begin
            err_reg   <= 1'b1;
            state_reg <= S_DONE;
          end else begin
            cnt_reg <= cnt_reg + 32'h00000001;
          end
        end
        S_DONE: begin
          rsp_valid <= 1'b1;
          rsp_error <= err_reg;
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // ****
  // pin cycle engine
  // ****
  flash_bus_cycle #(
    .ADDR_W (ADDR_W)
  ) u_cycle (
    .clk       (clk),
    .rst       (rst),
    .start     (cyc_start_reg),
    .is_read   (seq_read),
    .byte_mode (!byte_n),
    .addr_in   (seq_addr),
    .lsb_in    (seq_last ? lsb_reg : 1'b0),
    .wdata     (seq_data),
    .done      (cyc_done),
    .rdata     (cyc_rdata),
    .ce_n      (ce_n),
    .oe_n      (oe_n),
    .we_n      (we_n),
    .addr_out  (addr_out),
    .dq_out    (dq_out),
    .dq_oe_n   (dq_oe_n),
    .dq_in     (dq_in)
  );

endmodule // flash_host_ctrl

// File: bench/flash_host_ctrl_assertions.sv
// pin and handshake assertions for the flash host controller
`timescale 1ns/10ps
module flash_host_ctrl_checker (
  // clock, reset, user side
  input wire        clk,
  input wire        rst,
  input wire        cmd_valid,
  input wire [3:0]  cmd_op,
  input wire        cmd_ready,
  input wire        rsp_valid,
  input wire        rsp_error,
  // flash pins
  input wire        ce_n,
  input wire        oe_n,
  input wire        we_n,
  input wire [23:0] addr_out,
  input wire [15:0] dq_oe_n,
  input wire        reset_n,
  input wire        byte_n,
  input wire        protect_accel_low,
  input wire        protect_accel_hv
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_write_gate_ok: assert property (!we_n |-> !ce_n && oe_n) else $error("bad write gate");
  a_read_floats: assert property (!oe_n |-> we_n && &dq_oe_n[14:0]) else $error("read");
  a_pulse_width: assert property ($fell(we_n) |-> !we_n [*7] ##1 we_n) else $error("we");
  a_addr_held: assert property (!we_n && !$fell(we_n) |-> $stable(addr_out)) else $error("addr");
  a_data_at_rise: assert property ($rose(we_n) |-> dq_oe_n != 16'hFFFF) else $error("data");
  a_byte_upper_float: assert property (!byte_n |-> dq_oe_n[14:8] == 7'h7F) else $error("byte");
  a_word_full: assert property (byte_n && !we_n |-> dq_oe_n == 16'h0000) else $error("word");
  a_pin_levels: assert property (protect_accel_hv |-> !protect_accel_low) else $error("pin");
  a_refuse_quiet: assert property (cmd_valid && cmd_ready && cmd_op > 4'hB
    |-> (ce_n [*3]) and (##2 rsp_valid && rsp_error)) else $error("refuse");
  a_reset_pulse: assert property ($fell(reset_n) |-> !reset_n [*8]) else $error("reset");
  c_write: cover property ($rose(we_n));
  c_refused: cover property (rsp_valid && rsp_error);
  c_byte_read: cover property (!byte_n && !oe_n);
endmodule // flash_host_ctrl_checker
bind flash_host_ctrl flash_host_ctrl_checker u_chk (.clk, .rst, .cmd_valid, .cmd_op, .cmd_ready,
  .rsp_valid, .rsp_error, .ce_n, .oe_n, .we_n, .addr_out, .dq_oe_n, .reset_n, .byte_n,
  .protect_accel_low, .protect_accel_hv);

// File: bench/flash_dev_model.sv
// behavioural model of the parallel nor flash seen by the host
`timescale 1ns/10ps
module flash_dev_model #(
  parameter [7:0] MAKER_ID = 8'h5D
) (
  // pins
  input  wire        clk,
  input  wire        ce_n,
  input  wire        oe_n,
  input  wire        we_n,
  input  wire        reset_n,
  input  wire        byte_n,
  input  wire        protect_accel_hv,
  input  wire        autoselect_hv,
  input  wire [23:0] addr_out,
  input  wire [15:0] dq_in,
  output wire [15:0] q_drv,
  output reg         ready_busy_n
);
  reg [15:0] mem [0:15];
  reg [15:0] junk = 16'h0000;
  reg [15:0] rd;
  reg [23:0] a;
  reg [2:0]  st = 3'h0;
  reg [5:0]  cnt;
  reg        go;
  integer    i;
  initial begin
    ready_busy_n = 1'b1;
    for (i = 0; i < 16; i = i + 1) mem[i] = 16'hFFFF;
  end
  // released lines show a pattern that changes every cycle
  always @(posedge clk) junk <= ~junk;
  always @(negedge reset_n) st = 3'h0;
  always @(negedge we_n) if (!ce_n && oe_n) a = addr_out;
  always @(posedge we_n) if (!ce_n && oe_n && reset_n) begin
    go = 1'b0;
    case (st)
      0: st = (a[11:0] == 12'h555 && dq_in[7:0] == 8'hAA) ? 3'h1
        : (protect_accel_hv && dq_in[7:0] == 8'hA0) ? 3'h3 : 3'h0;
      1: st = (a[11:0] == 12'h2AA && dq_in[7:0] == 8'h55) ? 3'h2 : 3'h0;
      2: st = (dq_in[7:0] == 8'hA0) ? 3'h3 : (dq_in[7:0] == 8'h25) ? 3'h4 : 3'h0;
      3: begin
        mem[a[3:0]] = mem[a[3:0]] & dq_in;
        go = 1'b1;
      end
      4: begin
        cnt = dq_in[5:0];
        st = 3'h5;
      end
      5: begin
        mem[a[3:0]] = mem[a[3:0]] & dq_in;
        if (cnt == 6'h00) st = 3'h6;
        else cnt = cnt - 6'h01;
      end
      default: go = (dq_in[7:0] == 8'h29);
    endcase
    if (go) begin
      st = 3'h0;
      ready_busy_n = 1'b0;
      ready_busy_n <= #200 1'b1;
    end
  end
  always @* begin
    rd = mem[addr_out[3:0]];
    if (autoselect_hv) rd = (addr_out[1:0] == 2'b00) ? {8'h00, MAKER_ID}
      : (addr_out[1:0] == 2'b11) ? 16'h0019 : 16'h0000;
    if (!byte_n) rd = {junk[15:8], dq_in[15] ? rd[15:8] : rd[7:0]};
  end
  assign q_drv = (reset_n && !ce_n && !oe_n) ? rd : junk;
endmodule // flash_dev_model

// File: bench/test_flash_host_ctrl.sv
// self-checking bench for the flash host controller
`timescale 1ns/10ps
`include "flash_host_regs.vh"
module test_flash_host_ctrl;
  localparam [7:0] ID = 8'h5D; // arbitrary id value
  reg         clk, rst, cmd_valid, cmd_lsb, cfg_byte_mode, cfg_protect, cfg_accel;
  reg  [3:0]  cmd_op;
  reg  [23:0] cmd_addr;
  reg  [15:0] cmd_data, got, wd, got_err;
  reg  [15:0] shadow [0:15];
  wire        cmd_ready, rsp_valid, rsp_error, need_reset, abort_pending, ce_n, oe_n, we_n;
  wire        reset_n, byte_n, protect_accel_low, protect_accel_hv, autoselect_hv, ready_busy_n;
  wire [23:0] addr_out;
  wire [15:0] rsp_data, dq_out, dq_oe_n, q_drv;
  wire [15:0] dq_in = (dq_out & ~dq_oe_n) | (q_drv & dq_oe_n);
  integer     fails, check_count, seed, i, k;
  flash_host_ctrl #(.OP_MAX_CYC(400)) u_dut (.clk, .rst, .cmd_valid, .cmd_op, .cmd_addr,
    .cmd_lsb, .cmd_data, .cmd_ready, .rsp_valid, .rsp_data, .rsp_error, .need_reset,
    .abort_pending, .cfg_byte_mode, .cfg_protect, .cfg_accel, .ce_n, .oe_n, .we_n, .addr_out,
    .dq_out, .dq_oe_n, .dq_in, .reset_n, .byte_n, .protect_accel_low, .protect_accel_hv,
    .autoselect_hv, .ready_busy_n);
  flash_dev_model #(.MAKER_ID(ID)) u_dev (.clk, .ce_n, .oe_n, .we_n, .reset_n, .byte_n,
    .protect_accel_hv, .autoselect_hv, .addr_out, .dq_in, .q_drv, .ready_busy_n);
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task run_op(input [3:0] op, input [23:0] a, input [15:0] d);
    integer n;
    begin
      n = 0;
      while (cmd_ready !== 1'b1 && n < 3000) begin
        @(negedge clk);
        n = n + 1;
      end
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_addr = a;
      cmd_data = d;
      @(negedge clk);
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 6000) begin
        @(negedge clk);
        n = n + 1;
      end
      if (n >= 3000) fails = fails + 1;
      got = rsp_data;
      got_err = {15'h0000, rsp_error};
    end
  endtask
  task close_out;
    begin
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  function [15:0] merge(input [15:0] old, input [15:0] nw);
    merge = old & nw;
  endfunction
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #400000;
    fails = fails + 1;
    close_out;
  end
  initial begin
    {rst, seed, fails, check_count} = {1'b1, 32'd81, 32'd0, 32'd0};
    {cmd_valid, cmd_op, cmd_addr, cmd_lsb, cmd_data} = 0;
    {cfg_byte_mode, cfg_protect, cfg_accel} = 3'b000;
    for (i = 0; i < 16; i = i + 1) shadow[i] = 16'hFFFF;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    run_op(`OP_AUTOSEL_READ, 24'h000000, 16'h0000);
    chk({8'h00, got[7:0]}, {8'h00, ID});
    run_op(`OP_AUTOSEL_READ, 24'h000003, 16'h0000);
    chk({8'h00, got[7:0]}, 16'h0019);
    run_op(`OP_AUTOSEL_READ, 24'h000002, 16'h0000);
    chk({15'h0000, got[0]}, 16'h0000);
    for (k = 0; k < 8; k = k + 1) begin
      i = $random(seed) & 7;
      wd = $random(seed);
      cfg_accel = k[0];
      @(negedge clk);
      run_op(`OP_PROGRAM, i[23:0], wd);
      shadow[i] = merge(shadow[i], wd);
      chk(got_err, 16'h0);
      run_op(`OP_READ, i[23:0], 16'h0000);
      chk(got, shadow[i]);
    end
    {cfg_accel, cfg_protect} = 2'b01;
    repeat (2) @(negedge clk);
    chk({15'h0000, protect_accel_low}, 16'h0001);
    cfg_protect = 1'b0;
    run_op(4'hC, 24'h0, 16'h0);
    chk(got_err, 16'h1);
    run_op(`OP_BUF_DATA, 24'h010004, 16'h0);
    chk(got_err, 16'h1);
    run_op(`OP_BUF_START, 24'h010000, 16'h0020);
    chk(got_err, 16'h1);
    run_op(`OP_BUF_START, 24'h010000, 16'h0001);
    run_op(`OP_BUF_DATA, 24'h010004, 16'h1234);
    run_op(`OP_BUF_DATA, 24'h010044, 16'h0);
    chk(got_err, 16'h1);
    run_op(`OP_BUF_DATA, 24'h010005, 16'h5678);
    run_op(`OP_BUF_CONFIRM, 24'h010000, 16'h0);
    chk(got_err, 16'h0);
    shadow[4] = merge(shadow[4], 16'h1234);
    shadow[5] = merge(shadow[5], 16'h5678);
    run_op(`OP_READ, 24'h010005, 16'h0);
    chk(got, shadow[5]);
    {cfg_byte_mode, cmd_lsb} = 2'b11;
    repeat (2) @(negedge clk);
    run_op(`OP_READ, 24'h4, 16'h0);
    chk({8'h00, got[7:0]}, {8'h00, shadow[4][15:8]});
    {cfg_byte_mode, cmd_lsb} = 2'b00;
    repeat (2) @(negedge clk);
    run_op(`OP_HW_RESET, 24'h0, 16'h0);
    chk(got_err, 16'h0);
    run_op(`OP_READ, 24'h4, 16'h0);
    chk(got, shadow[4]);
    run_op(`OP_SW_RESET, 24'h0, 16'h0);
    chk(got_err, 16'h0);
    close_out;
  end
endmodule // test_flash_host_ctrl
